// file: efd_cfg.svh
`ifndef EFD_CFG_SVH
`define EFD_CFG_SVH
// register offsets (byte addresses on the processor bus)
`define EFD_OFS_PKT_LEN 12'h021C
`define EFD_OFS_BUF_STAT 12'h021E
`define EFD_OFS_DATA 12'h0220
`define EFD_OFS_MAXPKT 12'h0204
`define EFD_OFS_CTRL 12'h0228
// control function bits
`define EFD_CTRL_VALIDATE_BIT 3
`define EFD_CTRL_CLEAR_BIT 4
// field widths
`define EFD_FIFO_SIZE_W 11
`define EFD_STAT_W 2
// reset values
`define EFD_RST_PKT_LEN 16'h0000
`define EFD_RST_STAT 2'b00
`define EFD_RST_DATA 32'h0000_0000
// byte steps per access
`define EFD_STEP16 16'h0002
`define EFD_STEP32 16'h0004
// processor timing the block relies on, in ns
`define EFD_T_FIRST_READ_NS 500
`define EFD_T_STAT_READ_NS 200
`endif

// file: efd_pkg.sv
package efd_pkg;
   typedef enum logic [1:0] {
      EFD_IDLE,
      EFD_FILL,
      EFD_READY
   } efd_buf_state_t;
endpackage

// file: efd_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module efd_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
   end
   assign in_ready = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else if (flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         level <= level + (AW+1)'(in_valid && in_ready) - (AW+1)'(out_valid && out_ready);
      end
   end
endmodule
`default_nettype wire

// file: efd_data_access.sv
`timescale 1ns/100ps
`default_nettype none
`include "efd_cfg.svh"
module efd_data_access #(
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic bus_reset,
   input wire logic mode32,
   input wire logic ep_is_in,
   input wire logic [11:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata,
   output logic wr_ready,
   input wire logic tx_token,
   output logic tx_valid,
   output logic [31:0] tx_data,
   output logic tx_last,
   output logic [15:0] tx_bytes,
   input wire logic rx_push,
   input wire logic [31:0] rx_data,
   input wire logic rx_ack,
   input wire logic [15:0] rx_count,
   output logic rx_ready
);
   // ****************************************
   // storage
   // ****************************************
   // a single FIFO serves the indexed endpoint; the direction selects its role
   logic f_in_valid;
   logic f_in_ready;
   logic [31:0] f_in_data;
   logic f_out_valid;
   logic f_out_ready;
   logic [31:0] f_out_data;
   logic [$clog2(DEPTH):0] f_level;
   logic flush;
   logic [15:0] pkt_len;
   logic [`EFD_FIFO_SIZE_W-1:0] fifo_size;
   logic [15:0] tx_count;
   logic [15:0] rx_left;
   logic [`EFD_STAT_W-1:0] fill;
   logic [15:0] tx_sent;
   efd_pkg::efd_buf_state_t tx_state;
   logic hit_data;
   logic data_wr;
   logic data_rd;
   logic ctrl_wr;
   logic tx_pop;
   logic tx_full_pkt;
   logic [15:0] step;
   logic [15:0] tx_target;

   initial begin
      if (DEPTH < 2) $error("depth too small");
   end

   function automatic logic [15:0] step_of(input logic m32, input logic [15:0] left);
      logic [15:0] s;
      s = m32 ? `EFD_STEP32 : `EFD_STEP16;
      step_of = (left < s) ? left : s;
   endfunction

   assign hit_data = (addr == `EFD_OFS_DATA);
   assign data_wr = wr && hit_data && ep_is_in && f_in_ready && (tx_state != efd_pkg::EFD_READY);
   assign data_rd = rd && hit_data && !ep_is_in && f_out_valid && (rx_left != '0);
   assign ctrl_wr = wr && (addr == `EFD_OFS_CTRL);
   assign step = mode32 ? `EFD_STEP32 : `EFD_STEP16;
   assign tx_target = (pkt_len != '0 && pkt_len < {5'b0_0000, fifo_size})
      ? pkt_len : {5'b0_0000, fifo_size};
   assign tx_full_pkt = (tx_count + step >= tx_target) && (tx_target != '0);
   assign wr_ready = ep_is_in ? (f_in_ready && tx_state != efd_pkg::EFD_READY) : 1'b1;
   assign tx_pop = (tx_state == efd_pkg::EFD_READY) && tx_token && f_out_valid;

   // ****************************************
   // fifo
   // ****************************************
   assign f_in_valid = ep_is_in ? data_wr : rx_push;
   assign f_in_data = ep_is_in ? wdata : rx_data;
   assign f_out_ready = ep_is_in ? tx_pop : data_rd;
   assign rx_ready = !ep_is_in && f_in_ready && (fill != 2'b11);
   assign flush = bus_reset
      || (ctrl_wr && wdata[`EFD_CTRL_CLEAR_BIT] && !ep_is_in)
      || (data_rd && rx_left <= step_of(mode32, rx_left));

   efd_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .flush(flush),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data),
      .level(f_level)
   );

   // ****************************************
   // packet length register
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pkt_len <= `EFD_RST_PKT_LEN;
         fifo_size <= '0;
      end else if (bus_reset) begin
         pkt_len <= `EFD_RST_PKT_LEN;
         fifo_size <= '0;
      end else if (wr && addr == `EFD_OFS_MAXPKT) begin
         fifo_size <= wdata[`EFD_FIFO_SIZE_W-1:0];
         pkt_len <= {5'b0_0000, wdata[`EFD_FIFO_SIZE_W-1:0]};
      end else if (wr && addr == `EFD_OFS_PKT_LEN) begin
         pkt_len <= wdata[15:0];
      end else if (rx_ack && !ep_is_in) begin
         pkt_len <= rx_count;
      end
   end

   // ****************************************
   // tx packet build
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_state <= efd_pkg::EFD_IDLE;
         tx_count <= '0;
         tx_sent <= '0;
      end else if (bus_reset) begin
         tx_state <= efd_pkg::EFD_IDLE;
         tx_count <= '0;
         tx_sent <= '0;
      end else begin
         unique case (tx_state)
            efd_pkg::EFD_IDLE, efd_pkg::EFD_FILL: begin
               if (data_wr) begin
                  tx_count <= tx_count + step;
                  tx_state <= efd_pkg::EFD_FILL;
                  if (tx_full_pkt) begin
                     tx_state <= efd_pkg::EFD_READY;
                  end
               end else if (ctrl_wr && wdata[`EFD_CTRL_VALIDATE_BIT] && ep_is_in) begin
                  tx_state <= efd_pkg::EFD_READY;
               end
            end
            efd_pkg::EFD_READY: begin
               if (tx_pop) begin
                  tx_sent <= tx_sent + `EFD_STEP32;
                  if (!(f_level > 1)) begin
                     tx_state <= efd_pkg::EFD_IDLE;
                     tx_count <= '0;
                     tx_sent <= '0;
                  end
               end
            end
         endcase
      end
   end

   assign tx_valid = tx_pop;
   assign tx_data = f_out_data;
   assign tx_last = tx_pop && (f_level == 1);
   assign tx_bytes = (tx_count > tx_target && tx_target != '0) ? tx_target : tx_count;

   // ****************************************
   // rx bookkeeping and fill status
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_left <= '0;
      end else if (flush) begin
         rx_left <= '0;
      end else if (rx_ack && !ep_is_in) begin
         rx_left <= rx_count;
      end else if (data_rd) begin
         rx_left <= rx_left - step_of(mode32, rx_left);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fill <= `EFD_RST_STAT;
      end else if (bus_reset) begin
         fill <= `EFD_RST_STAT;
      end else if (ep_is_in) begin
         fill <= (tx_state == efd_pkg::EFD_READY) ? 2'b01 : 2'b00;
      end else begin
         fill <= (rx_left != '0 || f_out_valid) ? 2'b01 : 2'b00;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= `EFD_RST_DATA;
      end else if (rd) begin
         unique case (addr)
            `EFD_OFS_DATA: begin
               if (!mode32 && rx_left == 16'h0001) begin
                  rdata <= {24'h00_0000, f_out_data[7:0]};
               end else if (mode32) begin
                  rdata <= data_rd ? f_out_data : `EFD_RST_DATA;
               end else begin
                  rdata <= data_rd ? {16'h0000, f_out_data[15:0]} : `EFD_RST_DATA;
               end
            end
            `EFD_OFS_PKT_LEN: rdata <= {16'h0000, pkt_len};
            `EFD_OFS_BUF_STAT: rdata <= {{(32-`EFD_STAT_W){1'b0}}, fill};
            default: rdata <= `EFD_RST_DATA;
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_tx_step: assert property (@(posedge clk) disable iff (rst || bus_reset)
      data_wr && !tx_full_pkt |=> tx_count == $past(tx_count) + $past(step))
      else $error("tx count did not step");
   a_auto_valid: assert property (@(posedge clk) disable iff (rst || bus_reset)
      data_wr && tx_full_pkt |=> tx_state == efd_pkg::EFD_READY)
      else $error("full packet not validated");
   a_force_valid: assert property (@(posedge clk) disable iff (rst || bus_reset)
      ctrl_wr && wdata[`EFD_CTRL_VALIDATE_BIT] && ep_is_in && !data_wr
      && tx_state != efd_pkg::EFD_READY |=> tx_state == efd_pkg::EFD_READY)
      else $error("validate bit ignored");
   a_rx_step: assert property (@(posedge clk) disable iff (rst || flush || rx_ack)
      data_rd |=> rx_left == $past(rx_left) - step_of($past(mode32), $past(rx_left)))
      else $error("rx count did not step");
   a_rx_autoclr: assert property (@(posedge clk) disable iff (rst)
      data_rd && rx_left <= step_of(mode32, rx_left) |=> f_level == 0 && rx_left == 0)
      else $error("rx buffer not cleared");
   a_clr_buf: assert property (@(posedge clk) disable iff (rst)
      ctrl_wr && wdata[`EFD_CTRL_CLEAR_BIT] && !ep_is_in |=> f_level == 0)
      else $error("clear bit ignored");
   a_maxpkt_load: assert property (@(posedge clk) disable iff (rst || bus_reset)
      wr && addr == `EFD_OFS_MAXPKT |=> pkt_len == {5'b0_0000, $past(wdata[10:0])})
      else $error("length not loaded");
   a_busrst_len: assert property (@(posedge clk) disable iff (rst)
      bus_reset |=> pkt_len == 16'h0000 && fill == 2'b00)
      else $error("bus reset left length");
   a_out_count: assert property (@(posedge clk) disable iff (rst || bus_reset)
      rx_ack && !ep_is_in && !(wr && (addr == `EFD_OFS_MAXPKT || addr == `EFD_OFS_PKT_LEN))
      |=> pkt_len == $past(rx_count))
      else $error("out count wrong");
   a_odd_lane: assert property (@(posedge clk) disable iff (rst)
      rd && hit_data && !mode32 && rx_left == 16'h0001 |=> rdata[31:8] == 24'h00_0000)
      else $error("odd byte not in low lane");

   c_full_packet: cover property (@(posedge clk) data_wr && tx_full_pkt);
   c_short_valid: cover property (@(posedge clk) tx_state == efd_pkg::EFD_READY && tx_count < tx_target);
   c_rx_drain: cover property (@(posedge clk) data_rd && rx_left <= step_of(mode32, rx_left));
   c_force_clear: cover property (@(posedge clk) ctrl_wr && wdata[`EFD_CTRL_CLEAR_BIT]);
endmodule
`default_nettype wire

// file: efd_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module efd_cpu_model (
   input wire logic clk,
   input wire logic wr_ready,
   output logic [11:0] addr,
   output logic wr,
   output logic rd,
   output logic [31:0] wdata
);
   initial begin
      addr = 12'h000;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 32'h0000_0000;
   end
   // ****************************************
   // processor accesses
   // ****************************************
   // endpoint index is fixed by the bench, so every access targets one endpoint
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      while (w && wr_ready !== 1'b1 && n < 64) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // firmware-side settling time before reading status or data
   task automatic settle(input int ns);
      repeat (ns / 4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// file: efd_data_access_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "efd_cfg.svh"
module efd_data_access_tb_top;
   typedef struct {logic [31:0] d; logic [31:0] m; logic l;} efd_exp_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bus_reset = 1'b0;
   logic mode32 = 1'b1;
   logic ep_is_in = 1'b1;
   logic tx_token = 1'b0;
   logic rx_push = 1'b0;
   logic [31:0] rx_data = 32'h0000_0000;
   logic rx_ack = 1'b0;
   logic [15:0] rx_count = 16'h0000;
   logic [11:0] addr;
   logic wr, rd, wr_ready, tx_valid, tx_last, rx_ready;
   logic [31:0] wdata, rdata, tx_data;
   logic [15:0] tx_bytes;
   logic rd_d = 1'b0;
   logic [31:0] seed = 32'h2344_40f3;
   logic [31:0] rxw [2];
   efd_exp_t rq[$];
   efd_exp_t tq[$];
   efd_exp_t e;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
`define CHK(a, x) begin checked++; if ((a) !== (x)) begin fails++; \
   $display("Error %0t: got %h expected %h", $time, a, x); end end
   initial begin
      forever #2 clk = ~clk;
   end
   efd_cpu_model cpu (.clk(clk), .wr_ready(wr_ready), .addr(addr), .wr(wr), .rd(rd),
      .wdata(wdata));
   efd_data_access #(.DEPTH(32)) dut (.clk(clk), .rst(rst), .bus_reset(bus_reset),
      .mode32(mode32), .ep_is_in(ep_is_in), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
      .rdata(rdata), .wr_ready(wr_ready), .tx_token(tx_token), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_bytes(tx_bytes), .rx_push(rx_push),
      .rx_data(rx_data), .rx_ack(rx_ack), .rx_count(rx_count), .rx_ready(rx_ready));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic test_done();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ****************************************
   // monitors: oldest note against each result
   // ****************************************
   always @(posedge clk) begin
      rd_d <= rd;
      cyc++;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end
   always @(negedge clk) begin
      if (rd_d) begin
         if (rq.size() == 0) begin
            fails++;
            $display("Error %0t: unexpected read result", $time);
         end else begin
            e = rq.pop_front();
            `CHK(rdata & e.m, e.d)
         end
      end
      if (tx_valid === 1'b1) begin
         if (tq.size() == 0) begin
            fails++;
            $display("Error %0t: unexpected tx word", $time);
         end else begin
            e = tq.pop_front();
            `CHK(tx_data & e.m, e.d)
            `CHK(tx_last, e.l)
         end
      end
   end
   // ****************************************
   // stimulus helpers
   // ****************************************
   task automatic rd_exp(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      rq.push_back('{d & m, m, 1'b0});
      cpu.acc(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wr_words(input int n, input logic [31:0] m);
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         tq.push_back('{seed & m, m, i == n - 1});
         cpu.acc(1'b1, `EFD_OFS_DATA, seed);
      end
   endtask
   task automatic tok(input int n);
      @(posedge clk);
      tx_token <= 1'b1;
      repeat (n) @(posedge clk);
      tx_token <= 1'b0;
   endtask
   task automatic rx_pkt(input int n, input logic [15:0] c);
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         rxw[i] = seed;
         @(posedge clk);
         rx_push <= 1'b1;
         rx_data <= seed;
      end
      @(posedge clk);
      rx_push <= 1'b0;
      rx_ack <= 1'b1;
      rx_count <= c;
      @(posedge clk);
      rx_ack <= 1'b0;
   endtask
   task automatic ctrl_pulse(input logic [31:0] bits);
      cpu.acc(1'b1, `EFD_OFS_CTRL, bits);
      cpu.acc(1'b1, `EFD_OFS_CTRL, 32'h0000_0000);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd_exp(`EFD_OFS_PKT_LEN, 32'h0000_0000, 32'h0000_ffff);
      rd_exp(`EFD_OFS_BUF_STAT, 32'h0000_0000, 32'h0000_00ff);
      rd_exp(`EFD_OFS_DATA, 32'h0000_0000, 32'hffff_ffff);
      cpu.acc(1'b1, `EFD_OFS_BUF_STAT, 32'h0000_0000);
      cpu.acc(1'b1, `EFD_OFS_MAXPKT, 32'h0000_0008);
      rd_exp(`EFD_OFS_PKT_LEN, 32'h0000_0008, 32'h0000_ffff);
      wr_words(2, 32'hffff_ffff);
      @(negedge clk);
      `CHK(tx_bytes, 16'h0008)
      cpu.settle(`EFD_T_STAT_READ_NS);
      rd_exp(`EFD_OFS_BUF_STAT, 32'h0000_0001, 32'h0000_00ff);
      tok(4);
      `CHK(tq.size(), 0)
      @(posedge clk);
      bus_reset <= 1'b1;
      @(posedge clk);
      bus_reset <= 1'b0;
      rd_exp(`EFD_OFS_PKT_LEN, 32'h0000_0000, 32'h0000_ffff);
      // short packet through the length register in 16-bit mode
      mode32 <= 1'b0;
      cpu.acc(1'b1, `EFD_OFS_MAXPKT, 32'h0000_0008);
      cpu.acc(1'b1, `EFD_OFS_PKT_LEN, 32'h0000_0004);
      wr_words(2, 32'h0000_ffff);
      @(negedge clk);
      `CHK(tx_bytes, 16'h0004)
      tok(4);
      // below-length packet must wait for the validate bit
      mode32 <= 1'b1;
      cpu.acc(1'b1, `EFD_OFS_PKT_LEN, 32'h0000_0008);
      wr_words(1, 32'hffff_ffff);
      tok(3);
      ctrl_pulse(32'h0000_0008);
      `CHK(tx_bytes, 16'h0004)
      tok(4);
      `CHK(tq.size(), 0)
      // OUT packet read back, then auto clear
      ep_is_in <= 1'b0;
      rx_pkt(2, 16'h0008);
      rd_exp(`EFD_OFS_PKT_LEN, 32'h0000_0008, 32'h0000_ffff);
      cpu.settle(`EFD_T_FIRST_READ_NS);
      rd_exp(`EFD_OFS_DATA, rxw[0], 32'hffff_ffff);
      rd_exp(`EFD_OFS_DATA, rxw[1], 32'hffff_ffff);
      rd_exp(`EFD_OFS_BUF_STAT, 32'h0000_0000, 32'h0000_00ff);
      @(negedge clk);
      `CHK(rx_ready, 1'b1)
      rd_exp(`EFD_OFS_DATA, 32'h0000_0000, 32'hffff_ffff);
      // forced discard of an unread packet
      rx_pkt(1, 16'h0004);
      ctrl_pulse(32'h0000_0010);
      rd_exp(`EFD_OFS_DATA, 32'h0000_0000, 32'hffff_ffff);
      // odd byte count on the 16-bit bus lands in the low lane
      mode32 <= 1'b0;
      rx_pkt(2, 16'h0003);
      rd_exp(`EFD_OFS_DATA, rxw[0], 32'h0000_ffff);
      rd_exp(`EFD_OFS_DATA, rxw[1], 32'h0000_00ff);
      repeat (4) @(posedge clk);
      `CHK(rq.size(), 0)
      test_done();
   end
endmodule
`default_nettype wire
